// ### pkg/stx_consts.svh
/*
  Constants for the skip, table read and XOR execution unit.
  Assumes a core that issues one decoded operation at a time.
*/
`ifndef STX_CONSTS_SVH
`define STX_CONSTS_SVH
`define STX_ZERO_BYTE 8'h00
`define STX_ONE_BYTE 8'h01
`define STX_LAST_PAGE 8'hFF
`define STX_ZERO_WORD 16'h0000
`endif

// ### pkg/stx_pkg.sv
/*
  Types for the execution unit.
  Assumes nothing beyond the constants header.
*/
package stx_pkg;
  typedef enum logic [3:0] {
    STX_OP_NONE,
    STX_OP_ZERO_TEST_SKIP,
    STX_OP_ZERO_COPY_SKIP,
    STX_OP_BIT_ZERO_SKIP,
    STX_OP_PAGE_TABLE_READ,
    STX_OP_LAST_PAGE_TABLE_READ,
    STX_OP_PREINC_PAGE_TABLE_READ,
    STX_OP_PREINC_LAST_TABLE_READ,
    STX_OP_XOR_TO_ACCUMULATOR,
    STX_OP_XOR_TO_MEMORY
  } stx_op_type;
endpackage

// ### design/stx_alu.sv
/*
  Combinational result and zero flag for the unit.
  Assumes operands are stable during the execute slot.
*/
`include "stx_consts.svh"
module stx_alu
  import stx_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] acc,
  input wire logic [WIDTH-1:0] mem,
  input wire logic [2:0] bit_sel,
  output logic [WIDTH-1:0] xor_res,
  output logic xor_zero,
  output logic byte_zero,
  output logic bit_zero
);
  assign xor_res = acc ^ mem;
  assign xor_zero = (xor_res == `STX_ZERO_BYTE);
  assign byte_zero = (mem == `STX_ZERO_BYTE);
  assign bit_zero = ~mem[bit_sel];
endmodule // stx_alu

// ### design/stx_exec.sv
/*
  Execution unit for skips, table reads and XOR.
  Assumes op_valid is a pulse taken only while busy is low, with mem_rdata
  valid in the cycle of op_valid and prog_rdata valid in the cycle prog_req is high.
*/
`include "stx_consts.svh"
module stx_exec
  import stx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic op_valid,
  input wire stx_op_type op_code,
  input wire logic [7:0] mem_addr,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] mem_rdata,
  input wire logic [15:0] prog_rdata,
  output logic mem_we,
  output logic [7:0] mem_waddr,
  output logic [7:0] mem_wdata,
  output logic prog_req,
  output logic [15:0] prog_addr,
  output logic [7:0] accumulator,
  output logic zero_flag,
  output logic [7:0] table_high_latch,
  output logic [7:0] table_pointer_low,
  output logic [7:0] table_pointer_high,
  output logic skip_pulse,
  output logic dummy_slot,
  output logic busy
);
  typedef enum logic [1:0] {ST_IDLE, ST_TABLE, ST_DUMMY} stx_state_type;
  stx_state_type state_r;
  logic [7:0] acc_r, tbl_lo_r, tbl_hi_r, latch_r, waddr_r, wdata_r, tbl_addr_r;
  logic zf_r, we_r, preq_r, skip_r, dummy_r, busy_r;
  logic [15:0] paddr_r;
  logic [7:0] xor_res;
  logic xor_zero, byte_zero, bit_zero;

  stx_alu #(.WIDTH(8)) u_alu (
    .acc(acc_r),
    .mem(mem_rdata),
    .bit_sel(bit_sel),
    .xor_res(xor_res),
    .xor_zero(xor_zero),
    .byte_zero(byte_zero),
    .bit_zero(bit_zero)
  );

  wire go = op_valid && (state_r == ST_IDLE);
  wire is_ztest = (op_code == STX_OP_ZERO_TEST_SKIP);
  wire is_zcopy = (op_code == STX_OP_ZERO_COPY_SKIP);
  wire is_bit = (op_code == STX_OP_BIT_ZERO_SKIP);
  wire is_xa = (op_code == STX_OP_XOR_TO_ACCUMULATOR);
  wire is_xm = (op_code == STX_OP_XOR_TO_MEMORY);
  wire is_pre = (op_code == STX_OP_PREINC_PAGE_TABLE_READ) ||
                (op_code == STX_OP_PREINC_LAST_TABLE_READ);
  wire is_last = (op_code == STX_OP_LAST_PAGE_TABLE_READ) ||
                 (op_code == STX_OP_PREINC_LAST_TABLE_READ);
  wire is_tbl = is_pre || is_last || (op_code == STX_OP_PAGE_TABLE_READ);
  wire take_skip = ((is_ztest || is_zcopy) && byte_zero) || (is_bit && bit_zero);
  wire [7:0] tbl_lo_inc = tbl_lo_r + `STX_ONE_BYTE;
  wire [7:0] ptr_lo = is_pre ? tbl_lo_inc : tbl_lo_r;
  wire [7:0] ptr_hi = is_last ? `STX_LAST_PAGE : tbl_hi_r;
  wire mem_write = is_ztest || is_xm;
  wire [7:0] write_val = is_xm ? xor_res : mem_rdata;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      acc_r <= `STX_ZERO_BYTE;
      zf_r <= 1'b0;
      tbl_lo_r <= `STX_ZERO_BYTE;
      tbl_hi_r <= `STX_ZERO_BYTE;
      latch_r <= `STX_ZERO_BYTE;
      waddr_r <= `STX_ZERO_BYTE;
      wdata_r <= `STX_ZERO_BYTE;
      tbl_addr_r <= `STX_ZERO_BYTE;
      paddr_r <= `STX_ZERO_WORD;
      we_r <= 1'b0;
      preq_r <= 1'b0;
      skip_r <= 1'b0;
      dummy_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      we_r <= 1'b0;
      preq_r <= 1'b0;
      skip_r <= 1'b0;
      dummy_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (go) begin
            waddr_r <= mem_addr;
            wdata_r <= write_val;
            we_r <= mem_write;
            if (is_zcopy) begin
              acc_r <= mem_rdata;
            end
            if (is_xa) begin
              acc_r <= xor_res;
            end
            if (is_xa || is_xm) begin
              zf_r <= xor_zero;
            end
            if (is_pre) begin
              tbl_lo_r <= tbl_lo_inc;
            end
            if (is_tbl) begin
              paddr_r <= {ptr_hi, ptr_lo};
              preq_r <= 1'b1;
              tbl_addr_r <= mem_addr;
              busy_r <= 1'b1;
              state_r <= ST_TABLE;
            end else if (take_skip) begin
              skip_r <= 1'b1;
              busy_r <= 1'b1;
              state_r <= ST_DUMMY;
            end
          end
        end
        ST_TABLE: begin
          latch_r <= prog_rdata[15:8];
          waddr_r <= tbl_addr_r;
          wdata_r <= prog_rdata[7:0];
          we_r <= 1'b1;
          busy_r <= 1'b0;
          state_r <= ST_IDLE;
        end
        ST_DUMMY: begin
          dummy_r <= 1'b1;
          busy_r <= 1'b0;
          state_r <= ST_IDLE;
        end
        default: begin
          busy_r <= 1'b0;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign mem_we = we_r;
  assign mem_waddr = waddr_r;
  assign mem_wdata = wdata_r;
  assign prog_req = preq_r;
  assign prog_addr = paddr_r;
  assign accumulator = acc_r;
  assign zero_flag = zf_r;
  assign table_high_latch = latch_r;
  assign table_pointer_low = tbl_lo_r;
  assign table_pointer_high = tbl_hi_r;
  assign skip_pulse = skip_r;
  assign dummy_slot = dummy_r;
  assign busy = busy_r;

  property p_skip_dummy;
    @(posedge sys_clk) disable iff (sys_rst) skip_r |=> dummy_r && !busy_r;
  endproperty
  a_skip_dummy: assert property (p_skip_dummy) else $error("no dummy after skip");

  property p_ztest_skip;
    @(posedge sys_clk) disable iff (sys_rst)
      go && is_ztest |=> (skip_r == $past(byte_zero)) && zf_r == $past(zf_r);
  endproperty
  a_ztest_skip: assert property (p_ztest_skip) else $error("zero test skip wrong");

  property p_ztest_wb;
    @(posedge sys_clk) disable iff (sys_rst)
      go && is_ztest |=> we_r && wdata_r == $past(mem_rdata) && waddr_r == $past(mem_addr);
  endproperty
  a_ztest_wb: assert property (p_ztest_wb) else $error("write back missing");

  property p_zcopy;
    @(posedge sys_clk) disable iff (sys_rst)
      go && is_zcopy |=> acc_r == $past(mem_rdata) && skip_r == (acc_r == `STX_ZERO_BYTE);
  endproperty
  a_zcopy: assert property (p_zcopy) else $error("copy skip wrong");

  property p_bit;
    @(posedge sys_clk) disable iff (sys_rst)
      go && is_bit |=> skip_r == $past(bit_zero) && !we_r && zf_r == $past(zf_r);
  endproperty
  a_bit: assert property (p_bit) else $error("bit skip wrong");

  property p_page;
    @(posedge sys_clk) disable iff (sys_rst)
      go && (op_code == STX_OP_PAGE_TABLE_READ) |=> prog_addr == {tbl_hi_r, tbl_lo_r}
        ##1 we_r && latch_r == $past(prog_rdata[15:8]);
  endproperty
  a_page: assert property (p_page) else $error("page read wrong");

  property p_last;
    @(posedge sys_clk) disable iff (sys_rst)
      go && is_last |=> prog_addr[15:8] == `STX_LAST_PAGE && prog_addr[7:0] == tbl_lo_r;
  endproperty
  a_last: assert property (p_last) else $error("last page wrong");

  property p_preinc;
    @(posedge sys_clk) disable iff (sys_rst)
      go && is_pre |=> tbl_lo_r == $past(tbl_lo_r) + `STX_ONE_BYTE && tbl_hi_r == $past(tbl_hi_r);
  endproperty
  a_preinc: assert property (p_preinc) else $error("preincrement wrong");

  property p_preinc_last;
    @(posedge sys_clk) disable iff (sys_rst)
      go && (op_code == STX_OP_PREINC_LAST_TABLE_READ) |=> prog_addr == {`STX_LAST_PAGE, tbl_lo_r};
  endproperty
  a_preinc_last: assert property (p_preinc_last) else $error("preinc last wrong");

  property p_xa;
    @(posedge sys_clk) disable iff (sys_rst)
      go && is_xa |=> acc_r == ($past(acc_r) ^ $past(mem_rdata)) && !we_r;
  endproperty
  a_xa: assert property (p_xa) else $error("xor to acc wrong");

  property p_xm;
    @(posedge sys_clk) disable iff (sys_rst)
      go && is_xm |=> we_r && acc_r == $past(acc_r) && wdata_r == ($past(acc_r) ^ $past(mem_rdata));
  endproperty
  a_xm: assert property (p_xm) else $error("xor to mem wrong");

  property p_zf;
    @(posedge sys_clk) disable iff (sys_rst)
      go && (is_xa || is_xm) |=> zf_r == ($past(xor_res) == `STX_ZERO_BYTE);
  endproperty
  a_zf: assert property (p_zf) else $error("zero flag wrong");

  c_skip: cover property (@(posedge sys_clk) disable iff (sys_rst) skip_r ##1 dummy_r);
  c_table: cover property (@(posedge sys_clk) disable iff (sys_rst) prog_req ##1 we_r);
  c_xor_zero: cover property (@(posedge sys_clk) disable iff (sys_rst) go && is_xm && xor_zero);
endmodule // stx_exec

// ### verification/stx_mem_model.sv
/*
  Data memory and program memory model for the execution unit.
  Assumes one clock, data read combinational, program word read on request.
*/
module stx_mem_model (
  input wire logic sys_clk,
  input wire logic [7:0] mem_addr,
  output logic [7:0] mem_rdata,
  input wire logic mem_we,
  input wire logic [7:0] mem_waddr,
  input wire logic [7:0] mem_wdata,
  input wire logic prog_req,
  input wire logic [15:0] prog_addr,
  output logic [15:0] prog_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] data_r [256];
  logic held_r = 1'b0;
  logic [15:0] word;
  // Word from address, inverted unless requested in this or the previous cycle
  assign word = {prog_addr[7:0] ^ 8'hA5, prog_addr[15:8] ^ prog_addr[7:0] ^ 8'h3C};
  assign prog_rdata = (prog_req | held_r) ? word : ~word;
  assign mem_rdata = data_r[mem_addr];
  initial begin
    for (int i = 0; i < 256; i++) data_r[i] = (i % 5 == 0) ? 8'h00 : 8'(i * 37);
  end
  always @(posedge sys_clk) begin
    held_r <= prog_req;
    if (mem_we) data_r[mem_waddr] <= mem_wdata;
  end
endmodule // stx_mem_model

// ### verification/skip_table_xor_instructions_test.sv
/*
  Self-checking bench for the execution unit with its memory model.
  Assumes the unit answers as described in its hand-over timing.
*/
module skip_table_xor_instructions_test import stx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, sys_rst = 1'b1, op_valid = 1'b0;
  stx_op_type op_code = STX_OP_NONE;
  logic [7:0] mem_addr = 8'h00, mem_rdata, mem_waddr, mem_wdata, accumulator;
  logic [7:0] table_high_latch, table_pointer_low, table_pointer_high;
  logic [2:0] bit_sel = 3'h0;
  logic [15:0] prog_rdata, prog_addr;
  logic mem_we, prog_req, zero_flag, skip_pulse, dummy_slot, busy;
  logic [7:0] shadow [256];
  logic [7:0] acc_e = 8'h00, tpl_e = 8'h00;
  logic z_e = 1'b0;
  logic [31:0] lfsr_r = 32'h1EB7;
  int failures = 0, checks_done = 0;
  stx_exec DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .op_valid(op_valid), .op_code(op_code),
    .mem_addr(mem_addr), .bit_sel(bit_sel), .mem_rdata(mem_rdata), .prog_rdata(prog_rdata),
    .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .prog_req(prog_req),
    .prog_addr(prog_addr), .accumulator(accumulator), .zero_flag(zero_flag),
    .table_high_latch(table_high_latch), .table_pointer_low(table_pointer_low),
    .table_pointer_high(table_pointer_high), .skip_pulse(skip_pulse),
    .dummy_slot(dummy_slot), .busy(busy));
  stx_mem_model mem_model (.sys_clk(sys_clk), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .prog_req(prog_req),
    .prog_addr(prog_addr), .prog_rdata(prog_rdata));
  initial forever #2 sys_clk = ~sys_clk;
  function automatic logic [15:0] prog_word(logic [15:0] a);
    return {a[7:0] ^ 8'hA5, a[15:8] ^ a[7:0] ^ 8'h3C};
  endfunction
  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction
  task automatic chk(logic [23:0] seen, logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    acc_e = 8'h00;
    z_e = 1'b0;
    tpl_e = 8'h00;
    #1;
    chk({accumulator, table_high_latch, table_pointer_low}, 24'h0);
    chk({zero_flag, busy, skip_pulse, mem_we, prog_req, table_pointer_high}, 24'h0);
  endtask
  task automatic run_op(int k, logic [7:0] a, logic [2:0] b, logic intr);
    logic skip_e, tab, last;
    logic [15:0] w, pa;
    logic [7:0] m, res;
    m = shadow[a];
    res = acc_e ^ m;
    tab = k inside {[4:7]};
    last = k == 5 || k == 7;
    skip_e = ((k == 1 || k == 2) && m == 8'h00) || (k == 3 && !m[b]);
    if (k == 6 || k == 7) tpl_e = tpl_e + 8'h01;
    pa = {last ? 8'hFF : 8'h00, tpl_e};
    w = prog_word(pa);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_code <= stx_op_type'(k);
    mem_addr <= a;
    bit_sel <= b;
    @(posedge sys_clk);
    op_valid <= intr & (skip_e | tab);
    op_code <= STX_OP_XOR_TO_ACCUMULATOR;
    #1;
    if (k == 8) acc_e = res;
    if (k == 2) acc_e = m;
    if (k == 8 || k == 9) z_e = res == 8'h00;
    if (k == 9) shadow[a] = res;
    chk(accumulator, acc_e);
    chk(zero_flag, z_e);
    chk(skip_pulse, skip_e);
    chk(busy, skip_e | tab);
    chk(mem_we, k == 1 || k == 9);
    if (k == 1 || k == 9) chk({mem_waddr, mem_wdata}, {a, shadow[a]});
    chk(prog_req, tab);
    if (tab) chk(prog_addr, pa);
    chk(table_pointer_low, tpl_e);
    @(posedge sys_clk);
    op_valid <= 1'b0;
    #1;
    chk({dummy_slot, busy}, {skip_e, 1'b0});
    chk(mem_we, tab);
    if (tab) shadow[a] = w[7:0];
    if (tab) chk({mem_waddr, mem_wdata, table_high_latch}, {a, w[7:0], w[15:8]});
    chk({zero_flag, accumulator, table_pointer_high}, {z_e, acc_e, 8'h00});
  endtask
  initial begin
    for (int i = 0; i < 256; i++) shadow[i] = (i % 5 == 0) ? 8'h00 : 8'(i * 37);
    do_reset();
    for (int k = 0; k < 10; k++) run_op(k, 8'h00, 3'(k), 1'b1);
    for (int k = 0; k < 10; k++) run_op(k, 8'h01, 3'(k), 1'b1);
    run_op(2, 8'h03, 3'h0, 1'b0);
    run_op(8, 8'h03, 3'h0, 1'b0);
    run_op(9, 8'h02, 3'h0, 1'b0);
    $display("test opcodes done");
    for (int i = 0; i < 258; i++) run_op(7, 8'h10, 3'h0, 1'b0);
    $display("test pointer wrap done");
    for (int i = 0; i < 300; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      run_op(int'(lfsr_r[3:0]) % 10, lfsr_r[11:4], lfsr_r[14:12], lfsr_r[15]);
      if (i == 150) do_reset();
    end
    $display("test random done");
    close_out();
  end
endmodule // skip_table_xor_instructions_test
